// >>> hw/sioc_pkg.sv
package sioc_pkg;

    // Processor memory map
    localparam logic [15:0] SIOC_MISC_ADDR = 16'h6010;
    localparam logic [15:0] SIOC_VIDEO_ADDR = 16'h6012;
    localparam logic [15:0] SIOC_PROBE_CTRL_ADDR = 16'h6014;
    localparam logic [15:0] SIOC_PATTERN_BASE_ADDR = 16'h6018;
    localparam logic [15:0] SIOC_BUS_CTRL_BASE_ADDR = 16'h6800;
    localparam logic [2:0] SIOC_BUS_CTRL_DATA_INDEX = 3'h0;
    localparam int SIOC_PATTERN_BYTES = 5;

    // Miscellaneous register fields
    localparam int SIOC_MISC_SAMPLE_N_BIT = 0;
    localparam int SIOC_MISC_HOME_BIT = 1;
    localparam int SIOC_MISC_PEN_BIT = 2;
    localparam int SIOC_MISC_BELL_BIT = 3;
    localparam int SIOC_MISC_PEN_POL_BIT = 4;
    localparam logic [7:0] SIOC_MISC_RESET = 8'h01;

    // Word probe and lamp register fields
    localparam int SIOC_PROBE_MODE_LSB = 0;
    localparam int SIOC_PROBE_LAMP_LSB = 2;
    localparam int SIOC_PROBE_BUS_RESET_BIT = 5;
    localparam int SIOC_PROBE_LOAD_BIT = 6;
    localparam int SIOC_PROBE_SELECT_BIT = 7;
    localparam logic [7:0] SIOC_PROBE_CTRL_RESET = 8'h20;

    // Video option register fields
    localparam int SIOC_VIDEO_FIELD_BIT = 0;
    localparam int SIOC_VIDEO_NEGATIVE_SYNC_SELECT_BIT = 1;
    localparam int SIOC_VIDEO_CHANNEL_TWO_OFFSET_INVERT_BIT = 2;
    localparam int SIOC_VIDEO_CLAMP_BIT = 3;
    localparam int SIOC_VIDEO_FAST_CLAMP_BIT = 4;
    localparam int SIOC_VIDEO_TRIG_EN_BIT = 5;
    localparam int SIOC_VIDEO_LINE_COUPLE_BIT = 6;
    localparam logic [7:0] SIOC_VIDEO_RESET = 8'h00;

    // Probe serial load
    localparam int SIOC_PROBE_BITS = 40;
    localparam int SIOC_CLK_PERIOD_NS = 100;
    localparam int SIOC_PROBE_HALF_NS = 500;
    localparam int SIOC_PROBE_HALF_CYCLES =
        (SIOC_PROBE_HALF_NS + SIOC_CLK_PERIOD_NS - 1) / SIOC_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        SIOC_LOAD_IDLE,
        SIOC_LOAD_SETUP,
        SIOC_LOAD_CLK_HIGH
    } sioc_load_state_type;

endpackage

// >>> hw/sioc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sioc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;
endmodule // sioc_sync
`default_nettype wire

// >>> hw/sioc_top.sv
`timescale 1ns/1ps
`default_nettype none
module sioc_top
    import sioc_pkg::*;
#(
    parameter int PROBE_BITS = SIOC_PROBE_BITS
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    output logic [7:0] cpu_rdata,
    input wire logic bus_ctrl_rx_done,
    input wire logic [7:0] bus_ctrl_rdata,
    output logic bus_ctrl_sel,
    output logic [2:0] bus_ctrl_index,
    output logic bus_ctrl_wr,
    output logic bus_ctrl_rd,
    output logic [7:0] bus_ctrl_wdata,
    output logic bus_controller_reset,
    output logic bus_receive_interrupt,
    output logic [2:0] bus_lamps,
    output logic plot_sample_enable_n,
    output logic pen_home_select,
    output logic pen_raise,
    input wire logic tone_osc,
    output logic speaker_drive,
    output logic [1:0] probe_mode,
    output logic probe_data,
    output logic probe_clk,
    input wire logic probe_match,
    output logic word_match_trigger,
    output logic second_field,
    output logic negative_sync_select,
    output logic channel_two_offset_invert,
    output logic video_backporch_clamp,
    output logic video_fast_clamp,
    output logic video_trigger_enable,
    output logic video_line_coupling
);
    localparam int CNT_W = $clog2(PROBE_BITS + 1);
    localparam int HALF_W = $clog2(SIOC_PROBE_HALF_CYCLES + 1);
    localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(SIOC_PROBE_HALF_CYCLES - 1);
    localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(PROBE_BITS - 1);

    // Pin inputs pass two flip-flops before use
    logic rx_done_sync;
    logic [7:0] rdata_sync;
    logic tone_sync;
    logic match_sync;

    sioc_sync #(.WIDTH(11)) u_pin_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in({bus_ctrl_rx_done, bus_ctrl_rdata, tone_osc, probe_match}),
        .sync_out({rx_done_sync, rdata_sync, tone_sync, match_sync})
    );

    // Address decode
    logic bus_ctrl_hit;
    logic wr_misc;
    logic wr_video;
    logic wr_probe;
    logic data_reg_read;

    always_comb begin
        bus_ctrl_hit = (cpu_addr[15:3] == SIOC_BUS_CTRL_BASE_ADDR[15:3]);
        wr_misc = cpu_wr && (cpu_addr == SIOC_MISC_ADDR);
        wr_video = cpu_wr && (cpu_addr == SIOC_VIDEO_ADDR);
        wr_probe = cpu_wr && (cpu_addr == SIOC_PROBE_CTRL_ADDR);
        data_reg_read = cpu_rd && bus_ctrl_hit && (cpu_addr[2:0] == SIOC_BUS_CTRL_DATA_INDEX);
    end

    // Register bank state
    logic [7:0] misc_reg, misc_next;
    logic [7:0] video_reg, video_next;
    logic [7:0] probe_ctrl_reg, probe_ctrl_next;
    logic [7:0] pattern_reg [SIOC_PATTERN_BYTES];
    logic [7:0] pattern_next [SIOC_PATTERN_BYTES];
    logic rx_seen_reg, rx_seen_next;
    logic irq_reg, irq_next;
    logic [7:0] rdata_reg, rdata_next;
    logic sel_reg, sel_next;
    logic [2:0] index_reg, index_next;
    logic ctrl_wr_reg, ctrl_wr_next;
    logic ctrl_rd_reg, ctrl_rd_next;
    logic [7:0] wdata_reg, wdata_next;
    logic speaker_reg, speaker_next;
    logic trigger_reg, trigger_next;
    logic pen_reg, pen_next;
    logic load_busy;

    always_comb begin
        misc_next = misc_reg;
        video_next = video_reg;
        probe_ctrl_next = probe_ctrl_reg;
        for (int i = 0; i < SIOC_PATTERN_BYTES; i++) begin
            pattern_next[i] = pattern_reg[i];
            if (cpu_wr && (cpu_addr == SIOC_PATTERN_BASE_ADDR + 16'(i))) begin
                pattern_next[i] = cpu_wdata;
            end
        end
        if (wr_misc) begin
            misc_next = cpu_wdata;
        end
        // Only a processor write changes the setting
        if (wr_video) begin
            video_next = cpu_wdata;
        end
        if (wr_probe) begin
            probe_ctrl_next = cpu_wdata;
        end
        probe_ctrl_next[SIOC_PROBE_LOAD_BIT] = 1'b0;

        // Receive interrupt: a new byte wins over a clearing read
        rx_seen_next = rx_done_sync;
        irq_next = irq_reg;
        if (data_reg_read) begin
            irq_next = 1'b0;
        end
        if (rx_done_sync && !rx_seen_reg) begin
            irq_next = 1'b1;
        end

        // Controller access strobes
        sel_next = (cpu_wr || cpu_rd) && bus_ctrl_hit;
        index_next = bus_ctrl_hit ? cpu_addr[2:0] : index_reg;
        ctrl_wr_next = cpu_wr && bus_ctrl_hit;
        ctrl_rd_next = cpu_rd && bus_ctrl_hit;
        wdata_next = (cpu_wr && bus_ctrl_hit) ? cpu_wdata : wdata_reg;

        // Read data, one cycle after the strobe
        rdata_next = 8'h00;
        if (cpu_rd) begin
            if (bus_ctrl_hit) begin
                rdata_next = rdata_sync;
            end else if (cpu_addr == SIOC_MISC_ADDR) begin
                rdata_next = misc_reg;
            end else if (cpu_addr == SIOC_PROBE_CTRL_ADDR) begin
                rdata_next = probe_ctrl_reg;
                rdata_next[SIOC_PROBE_LOAD_BIT] = load_busy;
            end
        end

        speaker_next = misc_reg[SIOC_MISC_BELL_BIT] && tone_sync;
        trigger_next = match_sync && probe_ctrl_reg[SIOC_PROBE_SELECT_BIT];
        // Taken from the next value so the relay moves together with the other misc bits
        pen_next = misc_next[SIOC_MISC_PEN_BIT] ^ misc_next[SIOC_MISC_PEN_POL_BIT];
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            misc_reg <= SIOC_MISC_RESET;
            video_reg <= SIOC_VIDEO_RESET;
            probe_ctrl_reg <= SIOC_PROBE_CTRL_RESET;
            for (int i = 0; i < SIOC_PATTERN_BYTES; i++) begin
                pattern_reg[i] <= 8'h00;
            end
            rx_seen_reg <= 1'b0;
            irq_reg <= 1'b0;
            rdata_reg <= 8'h00;
            sel_reg <= 1'b0;
            index_reg <= 3'h0;
            ctrl_wr_reg <= 1'b0;
            ctrl_rd_reg <= 1'b0;
            wdata_reg <= 8'h00;
            speaker_reg <= 1'b0;
            trigger_reg <= 1'b0;
            pen_reg <= 1'b0;
        end else begin
            misc_reg <= misc_next;
            video_reg <= video_next;
            probe_ctrl_reg <= probe_ctrl_next;
            for (int i = 0; i < SIOC_PATTERN_BYTES; i++) begin
                pattern_reg[i] <= pattern_next[i];
            end
            rx_seen_reg <= rx_seen_next;
            irq_reg <= irq_next;
            rdata_reg <= rdata_next;
            sel_reg <= sel_next;
            index_reg <= index_next;
            ctrl_wr_reg <= ctrl_wr_next;
            ctrl_rd_reg <= ctrl_rd_next;
            wdata_reg <= wdata_next;
            speaker_reg <= speaker_next;
            trigger_reg <= trigger_next;
            pen_reg <= pen_next;
        end
    end

    // Probe serial loader, most significant bit first
    sioc_load_state_type state_reg, state_next;
    logic [PROBE_BITS-1:0] shift_reg, shift_next;
    logic [CNT_W-1:0] bit_cnt_reg, bit_cnt_next;
    logic [HALF_W-1:0] half_cnt_reg, half_cnt_next;
    logic pdata_reg, pdata_next;
    logic pclk_reg, pclk_next;
    logic [PROBE_BITS-1:0] pattern_flat;

    always_comb begin
        pattern_flat = '0;
        for (int i = 0; i < SIOC_PATTERN_BYTES; i++) begin
            pattern_flat[i*8 +: 8] = pattern_reg[i];
        end
        load_busy = (state_reg != SIOC_LOAD_IDLE);
        state_next = state_reg;
        shift_next = shift_reg;
        bit_cnt_next = bit_cnt_reg;
        half_cnt_next = half_cnt_reg;
        pdata_next = pdata_reg;
        pclk_next = pclk_reg;
        case (state_reg)
            SIOC_LOAD_IDLE: begin
                pclk_next = 1'b0;
                // A load request during a load is ignored
                if (wr_probe && cpu_wdata[SIOC_PROBE_LOAD_BIT]) begin
                    shift_next = pattern_flat;
                    bit_cnt_next = '0;
                    half_cnt_next = '0;
                    pdata_next = pattern_flat[PROBE_BITS-1];
                    state_next = SIOC_LOAD_SETUP;
                end
            end
            SIOC_LOAD_SETUP: begin
                // Data held a full half period before the rising edge
                if (half_cnt_reg == HALF_LAST) begin
                    half_cnt_next = '0;
                    pclk_next = 1'b1;
                    state_next = SIOC_LOAD_CLK_HIGH;
                end else begin
                    half_cnt_next = half_cnt_reg + 1'b1;
                end
            end
            SIOC_LOAD_CLK_HIGH: begin
                if (half_cnt_reg == HALF_LAST) begin
                    half_cnt_next = '0;
                    pclk_next = 1'b0;
                    shift_next = {shift_reg[PROBE_BITS-2:0], 1'b0};
                    pdata_next = shift_reg[PROBE_BITS-2];
                    if (bit_cnt_reg == BIT_LAST) begin
                        state_next = SIOC_LOAD_IDLE;
                    end else begin
                        bit_cnt_next = bit_cnt_reg + 1'b1;
                        state_next = SIOC_LOAD_SETUP;
                    end
                end else begin
                    half_cnt_next = half_cnt_reg + 1'b1;
                end
            end
            default: begin
                state_next = SIOC_LOAD_IDLE;
                pclk_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= SIOC_LOAD_IDLE;
            shift_reg <= '0;
            bit_cnt_reg <= '0;
            half_cnt_reg <= '0;
            pdata_reg <= 1'b0;
            pclk_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_next;
            half_cnt_reg <= half_cnt_next;
            pdata_reg <= pdata_next;
            pclk_reg <= pclk_next;
        end
    end

    assign cpu_rdata = rdata_reg;
    assign bus_ctrl_sel = sel_reg;
    assign bus_ctrl_index = index_reg;
    assign bus_ctrl_wr = ctrl_wr_reg;
    assign bus_ctrl_rd = ctrl_rd_reg;
    assign bus_ctrl_wdata = wdata_reg;
    assign bus_receive_interrupt = irq_reg;
    assign bus_controller_reset = probe_ctrl_reg[SIOC_PROBE_BUS_RESET_BIT];
    assign bus_lamps = probe_ctrl_reg[SIOC_PROBE_LAMP_LSB +: 3];
    assign probe_mode = probe_ctrl_reg[SIOC_PROBE_MODE_LSB +: 2];
    assign plot_sample_enable_n = misc_reg[SIOC_MISC_SAMPLE_N_BIT];
    assign pen_home_select = misc_reg[SIOC_MISC_HOME_BIT];
    assign pen_raise = pen_reg;
    assign speaker_drive = speaker_reg;
    assign probe_data = pdata_reg;
    assign probe_clk = pclk_reg;
    assign word_match_trigger = trigger_reg;
    assign second_field = video_reg[SIOC_VIDEO_FIELD_BIT];
    assign negative_sync_select = video_reg[SIOC_VIDEO_NEGATIVE_SYNC_SELECT_BIT];
    assign channel_two_offset_invert = video_reg[SIOC_VIDEO_CHANNEL_TWO_OFFSET_INVERT_BIT];
    assign video_backporch_clamp = video_reg[SIOC_VIDEO_CLAMP_BIT];
    assign video_fast_clamp = video_reg[SIOC_VIDEO_FAST_CLAMP_BIT];
    assign video_trigger_enable = video_reg[SIOC_VIDEO_TRIG_EN_BIT];
    assign video_line_coupling = video_reg[SIOC_VIDEO_LINE_COUPLE_BIT];
endmodule // sioc_top
`default_nettype wire

// >>> testbench/sioc_probe_model.sv
`timescale 1ns/1ps
`default_nettype none
module sioc_probe_model (
    input wire logic rst_n,
    input wire logic probe_clk,
    input wire logic probe_data,
    input wire logic [39:0] cond_word,
    output logic [39:0] word,
    output logic [7:0] nbits,
    output logic probe_match
);
    // One bit per rising clock edge; the first bit ends up on top
    always @(posedge probe_clk or negedge rst_n) begin
        if (!rst_n) begin
            word <= 40'h0;
            nbits <= 8'h00;
        end else begin
            word <= {word[38:0], probe_data};
            nbits <= nbits + 8'h01;
        end
    end
    // Extra clocks spoil the load, so match needs exactly forty
    assign probe_match = (nbits == 8'h28) && (word === cond_word);
endmodule // sioc_probe_model
`default_nettype wire

// >>> testbench/sioc_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sioc_top_assertions (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic bus_ctrl_rx_done,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic [2:0] bus_lamps,
    input wire logic [1:0] probe_mode,
    input wire logic bus_controller_reset,
    input wire logic bus_receive_interrupt,
    input wire logic plot_sample_enable_n,
    input wire logic pen_home_select,
    input wire logic pen_raise,
    input wire logic speaker_drive,
    input wire logic probe_data,
    input wire logic probe_clk,
    input wire logic probe_match,
    input wire logic word_match_trigger,
    input wire logic second_field,
    input wire logic negative_sync_select,
    input wire logic channel_two_offset_invert,
    input wire logic video_backporch_clamp,
    input wire logic video_fast_clamp,
    input wire logic video_trigger_enable,
    input wire logic video_line_coupling
);
    logic [6:0] video_bits;
    assign video_bits = {video_line_coupling, video_trigger_enable, video_fast_clamp, video_backporch_clamp,
        channel_two_offset_invert, negative_sync_select, second_field};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_irq_set;
        $rose(bus_ctrl_rx_done) |-> ##3 bus_receive_interrupt;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("receive interrupt late");
    property p_irq_clr;
        $stable(bus_ctrl_rx_done)[*4] ##0 (cpu_rd && cpu_addr == 16'h6800) |=> !bus_receive_interrupt;
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("receive interrupt kept after data read");
    property p_misc;
        cpu_wr && cpu_addr == 16'h6010 |=> plot_sample_enable_n == $past(cpu_wdata[0])
            && pen_home_select == $past(cpu_wdata[1]) && pen_raise == ($past(cpu_wdata[2]) ^ $past(cpu_wdata[4]));
    endproperty
    a_misc: assert property (p_misc) else $error("plotter outputs wrong");
    property p_probe_reg;
        cpu_wr && cpu_addr == 16'h6014 |=> {bus_controller_reset, bus_lamps, probe_mode} == $past(cpu_wdata[5:0]);
    endproperty
    a_probe_reg: assert property (p_probe_reg) else $error("lamp or mode wrong");
    property p_video;
        cpu_wr && cpu_addr == 16'h6012 |=> video_bits == $past(cpu_wdata[6:0]);
    endproperty
    a_video: assert property (p_video) else $error("video wrong");
    property p_video_hold;
        !(cpu_wr && cpu_addr == 16'h6012) |=> $stable(video_bits);
    endproperty
    a_video_hold: assert property (p_video_hold) else $error("video outputs moved");
    property p_bell_off;
        cpu_wr && cpu_addr == 16'h6010 && !cpu_wdata[3] |-> ##2 !speaker_drive;
    endproperty
    a_bell_off: assert property (p_bell_off) else $error("speaker on with bell low");
    property p_word_trig;
        !probe_match[*5] |-> !word_match_trigger;
    endproperty
    a_word_trig: assert property (p_word_trig) else $error("trigger without match");
    property p_probe_clk;
        $rose(probe_clk) |-> (probe_clk && $stable(probe_data))[*5] ##1 !probe_clk;
    endproperty
    a_probe_clk: assert property (p_probe_clk) else $error("probe clock phase wrong");
endmodule // sioc_top_assertions
bind sioc_top sioc_top_assertions i_sioc_top_assertions (.ref_clk, .rst_n, .cpu_wr, .cpu_rd,
    .bus_ctrl_rx_done, .cpu_addr, .cpu_wdata, .bus_lamps, .probe_mode, .bus_controller_reset,
    .bus_receive_interrupt, .plot_sample_enable_n, .pen_home_select, .pen_raise, .speaker_drive,
    .probe_data, .probe_clk, .probe_match, .word_match_trigger, .second_field, .negative_sync_select,
    .channel_two_offset_invert, .video_backporch_clamp, .video_fast_clamp, .video_trigger_enable,
    .video_line_coupling);
`default_nettype wire

// >>> testbench/sioc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sioc_top_bench;
    import sioc_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cpu_wr = 1'b0, cpu_rd = 1'b0, bus_ctrl_rx_done = 1'b0, tone_osc = 1'b0;
    logic [15:0] cpu_addr = 16'h0000, a;
    logic [7:0] cpu_wdata = 8'h00, bus_ctrl_rdata = 8'h00, cpu_rdata, bus_ctrl_wdata, q, d, nbits;
    logic bus_ctrl_sel, bus_ctrl_wr, bus_ctrl_rd, bus_controller_reset, bus_receive_interrupt, plot_sample_enable_n;
    logic pen_home_select, pen_raise, speaker_drive, probe_data, probe_clk, probe_match, word_match_trigger;
    logic second_field, negative_sync_select, channel_two_offset_invert, video_backporch_clamp;
    logic video_fast_clamp, video_trigger_enable, video_line_coupling;
    logic [2:0] bus_ctrl_index, bus_lamps, tone_div = 3'h0;
    logic [1:0] probe_mode;
    logic [39:0] cond_word = 40'h0, shifted, pattern;
    logic [31:0] rng = 32'h90dba4d6;
    logic [15:0] addr_tab [4] = '{SIOC_MISC_ADDR, SIOC_VIDEO_ADDR, SIOC_PROBE_CTRL_ADDR, 16'h6016};
    int num_errors = 0, cmp_count = 0, cycles = 0, misc_m = 1, probe_m = 32, video_m = 0, hi, e;
    sioc_top #(.PROBE_BITS(40)) i_sioc_top (.ref_clk, .rst_n, .cpu_addr, .cpu_wdata, .cpu_wr, .cpu_rd, .cpu_rdata,
        .bus_ctrl_rx_done, .bus_ctrl_rdata, .bus_ctrl_sel, .bus_ctrl_index, .bus_ctrl_wr, .bus_ctrl_rd,
        .bus_ctrl_wdata, .bus_controller_reset, .bus_receive_interrupt, .bus_lamps, .plot_sample_enable_n,
        .pen_home_select, .pen_raise, .tone_osc, .speaker_drive, .probe_mode, .probe_data, .probe_clk,
        .probe_match, .word_match_trigger, .second_field, .negative_sync_select, .channel_two_offset_invert,
        .video_backporch_clamp, .video_fast_clamp, .video_trigger_enable, .video_line_coupling);
    sioc_probe_model i_sioc_probe_model (.rst_n, .probe_clk, .probe_data, .cond_word, .word(shifted), .nbits,
        .probe_match);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] wa, input logic [7:0] wd);
        @(posedge ref_clk);
        #1 {cpu_wr, cpu_addr, cpu_wdata} = {1'b1, wa, wd};
        @(posedge ref_clk);
        #1 cpu_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] ra, output logic [7:0] rv);
        @(posedge ref_clk);
        #1 {cpu_rd, cpu_addr} = {1'b1, ra};
        @(posedge ref_clk);
        #1 cpu_rd = 1'b0;
        rv = cpu_rdata;
    endtask
    task automatic check_outs;
        chk("sample_n", misc_m[0], plot_sample_enable_n);
        chk("home", misc_m[1], pen_home_select);
        chk("pen", misc_m[2] ^ misc_m[4], pen_raise);
        chk("mode", probe_m[1:0], probe_mode);
        chk("lamps", probe_m[4:2], bus_lamps);
        chk("ctrl_reset", probe_m[5], bus_controller_reset);
        chk("video", video_m[6:0], {video_line_coupling, video_trigger_enable, video_fast_clamp,
            video_backporch_clamp, channel_two_offset_invert, negative_sync_select, second_field});
    endtask
    task automatic count_speaker(input int exp);
        repeat (4) @(posedge ref_clk);
        hi = 0;
        repeat (16) begin
            @(posedge ref_clk);
            #2 hi += speaker_drive;
        end
        chk("speaker", exp, hi);
    endtask
    task automatic tally_and_finish;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    // Free-running tone with an even duty, so any 16 cycles hold 8 highs
    always @(posedge ref_clk) begin
        #1 tone_div = tone_div + 3'h1;
        tone_osc = tone_div[2];
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        check_outs;
        chk("irq", 1'b0, bus_receive_interrupt);
        for (int i = 0; i < 40; i++) begin
            rng = xs(rng);
            a = addr_tab[rng[9:8]];
            d = rng[7:0] & ((a == SIOC_PROBE_CTRL_ADDR) ? 8'hbf : 8'hff);
            wr(a, d);
            misc_m = (a == SIOC_MISC_ADDR) ? d : misc_m;
            video_m = (a == SIOC_VIDEO_ADDR) ? d : video_m;
            probe_m = (a == SIOC_PROBE_CTRL_ADDR) ? d : probe_m;
            check_outs;
            rd(a, q);
            e = (a == SIOC_MISC_ADDR) ? (misc_m & 31) : ((a == SIOC_PROBE_CTRL_ADDR) ? probe_m : 0);
            chk("readback", e, (a == SIOC_MISC_ADDR) ? (q & 8'h1f) : q);
        end
        wr(SIOC_MISC_ADDR, 8'h08);
        misc_m = 8;
        count_speaker(8);
        wr(SIOC_MISC_ADDR, 8'h00);
        misc_m = 0;
        count_speaker(0);
        @(posedge ref_clk);
        #1 bus_ctrl_rdata = rng[23:16];
        bus_ctrl_rx_done = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 chk("irq", 1'b1, bus_receive_interrupt);
        rd(SIOC_BUS_CTRL_BASE_ADDR, q);
        chk("ctrl data", bus_ctrl_rdata, q);
        chk("ctrl read", {1'b1, 1'b1, 1'b0, 3'h0},
            {bus_ctrl_sel, bus_ctrl_rd, bus_ctrl_wr, bus_ctrl_index});
        chk("irq", 1'b0, bus_receive_interrupt);
        bus_ctrl_rx_done = 1'b0;
        wr(16'h6805, rng[31:24]);
        chk("ctrl write", {1'b1, 1'b1, 1'b0, 3'h5, rng[31:24]},
            {bus_ctrl_sel, bus_ctrl_wr, bus_ctrl_rd, bus_ctrl_index, bus_ctrl_wdata});
        rng = xs(rng);
        pattern = {rng, rng[15:8] ^ 8'h3c};
        for (int i = 0; i < SIOC_PATTERN_BYTES; i++) wr(SIOC_PATTERN_BASE_ADDR + 16'(i), pattern[8 * i +: 8]);
        wr(SIOC_PROBE_CTRL_ADDR, 8'hc1);
        probe_m = 8'h81;
        repeat (20) @(posedge ref_clk);
        wr(SIOC_PROBE_CTRL_ADDR, 8'hc1);
        q = 8'h40;
        for (int i = 0; i < 300 && q[6] !== 1'b0; i++) rd(SIOC_PROBE_CTRL_ADDR, q);
        chk("probe reg", probe_m, q);
        chk("probe bits", 40'd40, nbits);
        chk("probe word", pattern, shifted);
        cond_word = pattern;
        repeat (5) @(posedge ref_clk);
        #1 chk("word trig", 1'b1, word_match_trigger);
        wr(SIOC_PROBE_CTRL_ADDR, 8'h01);
        probe_m = 1;
        repeat (5) @(posedge ref_clk);
        #1 chk("word trig", 1'b0, word_match_trigger);
        check_outs;
        // Mid-run reset must bring back the power-up settings
        @(posedge ref_clk);
        #1 rst_n = 1'b0;
        misc_m = 1;
        probe_m = 32;
        video_m = 0;
        @(posedge ref_clk);
        #1 rst_n = 1'b1;
        check_outs;
        chk("irq", 1'b0, bus_receive_interrupt);
        tally_and_finish;
    end
endmodule // sioc_top_bench
`default_nettype wire
